// File: rtl/asr_rx.sv
// Purpose: Asynchronous receive path of the serial port unit.
// Assumes: Receive pin already synchronous to clk_sys_i; baud tick from divider.
// Notes: Overrun blocks reception until receive_enable is dropped.
// Operation
// - Receive only when receive_enable=1, clocked mode=0 and serial_port_enable=1.
// - serial_port_enable set makes the receive pin an input automatically.
// - serial_port_enable set drives the transmit pin from the port, latch cut off.
// - A falling edge on the idle line begins a character; start bit low.
// - At half bit the line must still be low, else silently drop.
// - Step full bits to centres, majority vote, shift into receive_shift_reg.
// - Stop bit sampled one bit later; low sets framing error for character.
// - Character and framing bit enter FIFO; receive_flag raised.
// - Reading receive_data_reg returns oldest character and pops it.
// - receive_flag high while enabled and an unread character waits.
// - Each FIFO entry keeps its framing bit; flag shows the oldest.
// - Clearing serial_port_enable resets port and flag; receive_enable does not.
`timescale 1ns/1ps
module asr_rx #(
    parameter int unsigned DEPTH = asr_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic serial_port_enable_i,
    input wire logic receive_enable_i,
    input wire logic clocked_mode_i,
    input wire logic [7:0] baud_div_i,
    input wire logic receive_pin_i,
    input wire logic tx_serial_i,
    input wire logic gp_latch_i,
    input wire logic receive_dir_i,
    input wire logic transmit_dir_i,
    input wire logic data_read_i,
    output logic [7:0] receive_data_reg_o,
    output logic framing_error_flag_o,
    output logic receive_flag_o,
    output logic overrun_flag_o,
    output logic receive_pin_oe_n_o,
    output logic transmit_pin_o,
    output logic transmit_pin_oe_n_o
);
    // Refuse a FIFO with no room at elaboration
    if (DEPTH < 1) begin : g_bad_depth
        $error("asr_rx: DEPTH must be at least one");
    end

    // ****************************************************************
    // Enables and pin steering
    // ****************************************************************
    logic rx_on;
    assign rx_on = receive_enable_i && !clocked_mode_i && serial_port_enable_i;

    // Port owns both pins while enabled; output enable is active low
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            receive_pin_oe_n_o <= 1'b1;
            transmit_pin_oe_n_o <= 1'b1;
            transmit_pin_o <= 1'b1;
        end else if (ce_i) begin
            receive_pin_oe_n_o <= serial_port_enable_i ? 1'b1 : receive_dir_i;
            transmit_pin_oe_n_o <= serial_port_enable_i ? 1'b0 : transmit_dir_i;
            transmit_pin_o <= serial_port_enable_i ? tx_serial_i : gp_latch_i;
        end
    end

    // ****************************************************************
    // Baud tick, sixteen per bit
    // ****************************************************************
    logic [7:0] div_r;
    logic tick;
    assign tick = (div_r == '0);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r <= asr_pkg::BAUD_DIV_RST;
        end else if (ce_i) begin
            div_r <= (tick || !rx_on) ? baud_div_i : div_r - 8'h01;
        end
    end

    // ****************************************************************
    // Receive state machine
    // ****************************************************************
    typedef enum logic [3:0] {
        ASR_IDLE = 4'b0001,
        ASR_START = 4'b0010,
        ASR_DATA = 4'b0100,
        ASR_STOP = 4'b1000
    } asr_state_t;
    asr_state_t state_r;
    logic [3:0] sub_r;
    logic [2:0] bit_r;
    logic [1:0] vote_r;
    logic [7:0] receive_shift_reg_r;
    logic line_prev_r;
    logic push;
    logic [8:0] push_data;
    logic maj;
    logic overrun_r;
    logic fifo_full;
    logic fifo_empty;
    logic [8:0] head;

    // Two of three samples decide the bit; the live pin is the centre sample,
    // so the vote is ready on the very tick that shifts it in
    assign maj = (vote_r[0] & vote_r[1]) | (vote_r[0] & receive_pin_i)
        | (vote_r[1] & receive_pin_i);

    // Remember previous line level for edge detection
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_prev_r <= 1'b1;
        end else if (ce_i) begin
            line_prev_r <= receive_pin_i;
        end
    end

    // Majority sampler stores the two ticks just before each centre
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vote_r <= 2'h3;
        end else if (ce_i && tick) begin
            if (sub_r == asr_pkg::VOTE_A) vote_r[0] <= receive_pin_i;
            if (sub_r == asr_pkg::VOTE_B) vote_r[1] <= receive_pin_i;
        end
    end

    // Sequencing, bit count and shift register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ASR_IDLE;
            sub_r <= '0;
            bit_r <= '0;
            receive_shift_reg_r <= asr_pkg::DATA_RST;
        end else if (ce_i) begin
            if (!rx_on) begin
                state_r <= ASR_IDLE;
            end else unique case (state_r)
                ASR_IDLE: begin
                    // Overrun holds off new characters
                    if (line_prev_r && !receive_pin_i && !overrun_r) begin
                        state_r <= ASR_START;
                        sub_r <= '0;
                    end
                end
                ASR_START: if (tick) begin
                    if (sub_r == asr_pkg::HALF_BIT_TICKS) begin
                        // A glitch drops quietly back to idle
                        state_r <= receive_pin_i ? ASR_IDLE : ASR_DATA;
                        sub_r <= '0;
                        bit_r <= '0;
                    end else begin
                        sub_r <= sub_r + 4'h1;
                    end
                end
                ASR_DATA: if (tick) begin
                    sub_r <= sub_r + 4'h1;
                    if (sub_r == asr_pkg::FULL_BIT_TICKS) begin
                        receive_shift_reg_r <= {maj, receive_shift_reg_r[7:1]};
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == 3'(asr_pkg::DATA_BITS - 1)) state_r <= ASR_STOP;
                    end
                end
                ASR_STOP: if (tick) begin
                    sub_r <= sub_r + 4'h1;
                    if (sub_r == asr_pkg::FULL_BIT_TICKS) state_r <= ASR_IDLE;
                end
                default: state_r <= ASR_IDLE;
            endcase
        end
    end

    // Stop bit low marks this character's framing error
    assign push = ce_i && rx_on && tick && state_r == ASR_STOP
        && sub_r == asr_pkg::FULL_BIT_TICKS;
    assign push_data = {!maj, receive_shift_reg_r};

    // Overrun: character arriving with FIFO full; cleared by dropping receive
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overrun_r <= 1'b0;
        end else if (ce_i) begin
            if (push && fifo_full) overrun_r <= 1'b1;
            else if (!rx_on) overrun_r <= 1'b0;
        end
    end

    // ****************************************************************
    // FIFO and read side
    // ****************************************************************
    asr_fifo #(
        .WIDTH(9),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .en_i(ce_i),
        .flush_i(!serial_port_enable_i),
        .push_i(push),
        .push_data_i(push_data),
        .pop_i(data_read_i),
        .head_o(head),
        .empty_o(fifo_empty),
        .full_o(fifo_full)
    );

    // Status outputs registered from FIFO head and overrun_r; framing bit travels with data
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            receive_data_reg_o <= asr_pkg::DATA_RST;
            framing_error_flag_o <= 1'b0;
            receive_flag_o <= 1'b0;
            overrun_flag_o <= 1'b0;
        end else if (ce_i) begin
            receive_data_reg_o <= head[7:0];
            framing_error_flag_o <= serial_port_enable_i && !fifo_empty && head[8];
            receive_flag_o <= receive_enable_i && serial_port_enable_i && !fifo_empty;
            overrun_flag_o <= overrun_r;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    start_glitch_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && rx_on && state_r == ASR_START && tick && sub_r == asr_pkg::HALF_BIT_TICKS
        && receive_pin_i |=> state_r == ASR_IDLE && !push)
        else $error("start glitch not dropped");
    disabled_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !rx_on |=> state_r == ASR_IDLE)
        else $error("receiver ran while disabled");
    tx_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && serial_port_enable_i |=> !transmit_pin_oe_n_o)
        else $error("transmit pin not driven");
    rx_input_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && serial_port_enable_i |=> receive_pin_oe_n_o)
        else $error("receive pin not input");
    flag_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && push && !fifo_full && receive_enable_i && serial_port_enable_i
        |=> ##1 receive_flag_o || !ce_i || data_read_i)
        else $error("receive flag missing after character");
    framing_error_flag_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !serial_port_enable_i |=> !framing_error_flag_o)
        else $error("framing flag survived port disable");
    overrun_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        overrun_r && state_r == ASR_IDLE |=> state_r == ASR_IDLE)
        else $error("character accepted during overrun");
    edge_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && rx_on && !overrun_r && state_r == ASR_IDLE && line_prev_r && !receive_pin_i
        |=> state_r == ASR_START)
        else $error("falling edge missed");
    stop_push_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        push |-> state_r == ASR_STOP && bit_r == '0)
        else $error("push outside stop bit");
endmodule : asr_rx

// File: rtl/asr_pkg.sv
// Purpose: Shared constants for the asynchronous serial receiver.
// Assumes: 10 MHz system clock, 8 data bits, one stop bit.
// Notes: Counts of baud ticks live here so both design files agree.
package asr_pkg;
    // ****************************************************************
    // Sizes and reset values
    // ****************************************************************
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned FIFO_DEPTH = 2;
    localparam logic [7:0] BAUD_DIV_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // Baud generator ticks sixteen times per bit
    localparam int unsigned OVERSAMPLE = 16;
    localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
    localparam logic [3:0] FULL_BIT_TICKS = 4'hF;
    // Counting restarts at the start-bit centre, so sub count 15 is a bit centre;
    // two stored votes lead it and the live pin at count 15 is the third vote
    localparam logic [3:0] VOTE_A = 4'hD;
    localparam logic [3:0] VOTE_B = 4'hE;
endpackage : asr_pkg

// File: rtl/asr_fifo.sv
// Purpose: Small receive FIFO holding each character with its framing bit.
// Assumes: Push and pop are single-cycle strobes; a push while full is dropped.
// Notes: Read data comes from a register that always shows the oldest entry.
`timescale 1ns/1ps
module asr_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic [WIDTH-1:0] push_data_i,
    input wire logic pop_i,
    output logic [WIDTH-1:0] head_o,
    output logic empty_o,
    output logic full_o
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Refuse sizes the pointers cannot serve
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
        $error("asr_fifo: bad size");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic do_push;
    logic do_pop;
    logic [AW-1:0] rd_nxt;
    assign do_pop = pop_i && (cnt_r != '0);
    assign do_push = push_i && (cnt_r != (AW+1)'(DEPTH));
    assign rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
    assign empty_o = (cnt_r == '0);
    assign full_o = (cnt_r == (AW+1)'(DEPTH));

    // Storage, no reset needed on data
    always_ff @(posedge clk_sys_i) begin
        if (en_i && do_push) begin
            mem_r[wr_r] <= push_data_i;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else if (en_i) begin
            if (flush_i) begin
                wr_r <= '0;
                rd_r <= '0;
                cnt_r <= '0;
            end else begin
                if (do_push) begin
                    wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
                end
                if (do_pop) begin
                    rd_r <= rd_nxt;
                end
                cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
            end
        end
    end

    // Head register: next oldest entry, bypassing a push into an empty slot
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            head_o <= '0;
        end else if (en_i) begin
            if (flush_i) begin
                head_o <= '0;
            end else if (do_pop) begin
                if (cnt_r > (AW+1)'(1)) begin
                    head_o <= mem_r[rd_nxt];
                end else if (do_push) begin
                    head_o <= push_data_i;
                end
            end else if (do_push && cnt_r == '0) begin
                head_o <= push_data_i;
            end
        end
    end
endmodule : asr_fifo

// File: sim/asr_tx_model.sv
// Purpose: Remote asynchronous transmitter driving the receive line.
// Assumes: A bit lasts a whole number of system clock cycles.
// Notes: Tasks are entered just after a rising edge of the clock.
`timescale 1ns/1ps
module asr_tx_model #(
    parameter int unsigned BIT_CYCLES = 32
) (
    input wire logic clk_sys_i,
    output logic line_o
);
    // ****************************************************************
    // Line driver
    // ****************************************************************
    // Idle high; the pin is left digital so the receiver sees it
    initial begin
        line_o = 1'b1;
    end

    // Hold one level for n cycles, changed just after an edge
    task automatic hold(input logic lvl, input int unsigned n);
        line_o <= lvl;
        repeat (n) @(posedge clk_sys_i);
    endtask : hold

    // Start low, data LSB first, chosen stop level, then idle
    task automatic send(input logic [7:0] data, input logic stop);
        hold(1'b0, BIT_CYCLES);
        for (int i = 0; i < 8; i++) begin
            hold(data[i], BIT_CYCLES);
        end
        hold(stop, BIT_CYCLES);
        hold(1'b1, BIT_CYCLES);
    endtask : send

    // Short low pulse that is gone before the half-bit check
    task automatic glitch;
        hold(1'b0, 3);
        hold(1'b1, 2 * BIT_CYCLES);
    endtask : glitch
endmodule : asr_tx_model

// File: sim/async_serial_receiver_tb_top.sv
// Purpose: Self-checking bench for the asynchronous receive path.
// Assumes: Divider value 1, so one bit is 32 system cycles.
// Notes: Clock enable drops once near the end to show that state freezes.
`timescale 1ns/1ps
module async_serial_receiver_tb_top;
    localparam logic [7:0] DIV = 8'h01;
    localparam int unsigned BITC = 32;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic spe = 1'b0;
    logic ren = 1'b0;
    logic cmode = 1'b0;
    logic tx_ser = 1'b1;
    logic rd = 1'b0;
    logic ce = 1'b1;
    logic rx_line;
    logic [7:0] data;
    logic fe, flag, ovr, rx_oe_n, tx_pin, tx_oe_n;
    int mismatches = 0;
    int n_compared = 0;

    // ****************************************************************
    // Clock, partner and design
    // ****************************************************************
    always #50 clk_sys_i = ~clk_sys_i;

    asr_tx_model #(.BIT_CYCLES(BITC)) u_tx (.clk_sys_i(clk_sys_i), .line_o(rx_line));

    asr_rx u_dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .serial_port_enable_i(spe), .receive_enable_i(ren),
        .clocked_mode_i(cmode), .baud_div_i(DIV), .receive_pin_i(rx_line),
        .tx_serial_i(tx_ser), .gp_latch_i(1'b0), .receive_dir_i(1'b0),
        .transmit_dir_i(1'b1), .data_read_i(rd), .receive_data_reg_o(data),
        .framing_error_flag_o(fe), .receive_flag_o(flag), .overrun_flag_o(ovr),
        .receive_pin_oe_n_o(rx_oe_n), .transmit_pin_o(tx_pin),
        .transmit_pin_oe_n_o(tx_oe_n)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Registered outputs need a few edges to settle
    task automatic settle;
        repeat (4) @(posedge clk_sys_i);
    endtask : settle

    // One-cycle read strobe; spacing kept above two edges
    task automatic pop;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        settle();
    endtask : pop

    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // Whole run is well under 8000 cycles; a hang is cut off here
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        stop_test();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clk_sys_i);
        check("rst data", data, 8'h00);
        check("rst pins", {fe, flag, ovr, rx_oe_n, tx_pin}, 8'h03);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        settle();
        // Port off: pins follow latch and direction bits
        check("off pins", {rx_oe_n, tx_pin, tx_oe_n}, 8'h01);
        spe <= 1'b1;
        settle();
        check("on pins", {rx_oe_n, tx_pin, tx_oe_n}, 8'h06);
        tx_ser <= 1'b0;
        settle();
        check("tx pin", tx_pin, 8'h00);
        // Reception blocked in clocked mode and with receiver off
        ren <= 1'b1;
        cmode <= 1'b1;
        u_tx.send(8'h5A, 1'b1);
        check("clocked", flag, 8'h00);
        ren <= 1'b0;
        cmode <= 1'b0;
        u_tx.send(8'h5A, 1'b1);
        check("rx off", flag, 8'h00);
        ren <= 1'b1;
        // Good character, bad-stop character, then overrun
        u_tx.send(8'hA5, 1'b1);
        settle();
        check("first", {flag, fe, data}, 16'h02A5);
        check("first flag", {flag, fe}, 8'h02);
        u_tx.send(8'h3C, 1'b0);
        check("head kept", {fe, data}, 16'h00A5);
        u_tx.send(8'h0F, 1'b1);
        settle();
        check("overrun", ovr, 8'h01);
        u_tx.send(8'h81, 1'b1);
        pop();
        check("second", data, 8'h3C);
        check("second fe", fe, 8'h01);
        ren <= 1'b0;
        settle();
        check("ren off", {fe, flag, ovr}, 8'h04);
        ren <= 1'b1;
        settle();
        pop();
        check("refused", flag, 8'h00);
        // Glitch dropped silently, next character still taken
        u_tx.glitch();
        check("glitch", {flag, fe, ovr}, 8'h00);
        u_tx.send(8'h66, 1'b1);
        u_tx.send(8'hC3, 1'b0);
        check("after glitch", data, 8'h66);
        pop();
        check("bad stop", {flag, fe, data}, 16'h03C3);
        check("bad stop fe", {flag, fe}, 8'h03);
        // Frozen: neither a read nor a port disable may act
        ce <= 1'b0;
        spe <= 1'b0;
        pop();
        check("frozen", {flag, fe, data}, 16'h03C3);
        ce <= 1'b1;
        settle();
        check("port off", {flag, fe}, 8'h00);
        stop_test();
    end
endmodule : async_serial_receiver_tb_top
